// >>> src/dcp_calib_pattern_readout.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - Mode register set with bank bits 0,1 high and bit 2 low targets register three.
// - Register three write with address bit two set enters pattern mode.
// - In pattern mode every read and autoprecharge read returns pattern data.
// - The external reset pin still clears the device in pattern mode.
// - In pattern mode an autoprecharge read acts as a plain read, no precharge.
// - With bit two clear, reads and writes use the array, location ignored.
// - Pattern reads give a one-bit stream on line zero, copied to the part's other lines if replication is set.
// - Four-bit part: line zero carries the bit, lines three to one copy or zero.
// - Eight-bit part: lowest lane line carries it, others copy or drive zero.
// - Pattern reads ignore bank bits and other column bits, autoprecharge too.
// - Eight-beat pattern reads need column bit two zero; order zero to seven.
// - Chopped reads give beats zero to three, or four to seven if bit set.
// - Chop address bit selects chop on the fly only if mode zero allows it.
// - Pattern reads use the same latency and timing as array reads.
// - Beat zero carries the pattern's low bit, beat seven its high bit.
// - Location zero returns the fixed alternating pattern 0,1,0,1.
// - Write termination switches without a set, chosen by register two bits.
// - In write leveling only the nominal termination applies.
// - Read latency is additive latency plus CAS latency.
module dcp_calib_pattern_readout (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ck,
    input wire logic pin_reset_n,
    input wire dcp_pkg::dcp_cmd_s cmd_pins,
    output logic [7:0] dq_out,
    output logic dq_oe,
    output logic [2:0] term_code,
    output logic term_dynamic,
    output logic bank_precharge,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import dcp_pkg::*;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [3:0] dcp_cl(input logic [14:0] mr0);
        return 4'(mr0[6:4] + DCP_CL_BASE);
    endfunction

    function automatic logic [3:0] dcp_al(input logic [14:0] mr1,
                                          input logic [3:0] cl);
        unique case (mr1[4:3])
            2'h1: return 4'(cl - 4'h1);
            2'h2: return 4'(cl - 4'h2);
            default: return 4'h0;
        endcase
    endfunction

    // ==========================================================
    // Synchronisers and link clock edges
    // ==========================================================
    logic ck_s1, ck_s2, ck_d;
    logic rst_s1, rst_s2;
    dcp_cmd_s cmd_s1, cmd_s2;
    logic ck_rise, ck_edge, dev_reset;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_d <= 1'b0;
            // Idle level of the reset pin, so no false device reset follows.
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
            cmd_s1 <= '1;
            cmd_s2 <= '1;
        end else begin
            ck_s1 <= ck;
            ck_s2 <= ck_s1;
            ck_d <= ck_s2;
            rst_s1 <= pin_reset_n;
            rst_s2 <= rst_s1;
            cmd_s1 <= cmd_pins;
            cmd_s2 <= cmd_s1;
        end
    end

    assign ck_rise = ck_s2 && !ck_d;
    assign ck_edge = ck_s2 != ck_d;
    assign dev_reset = !rst_s2;

    // ==========================================================
    // Command decode
    // ==========================================================
    logic cmd_sel, is_mrs, is_read, is_write;
    assign cmd_sel = ck_rise && !cmd_s2.cs_n;
    assign is_mrs = cmd_sel && !cmd_s2.ras_n && !cmd_s2.cas_n
                    && !cmd_s2.we_n;
    assign is_read = cmd_sel && cmd_s2.ras_n && !cmd_s2.cas_n
                     && cmd_s2.we_n;
    assign is_write = cmd_sel && cmd_s2.ras_n && !cmd_s2.cas_n
                      && !cmd_s2.we_n;

    // ==========================================================
    // Mode registers
    // ==========================================================
    logic [14:0] mode_reg_zero, mode_reg_one, mode_reg_two;
    logic [14:0] mode_reg_three;
    logic pattern_mode;
    logic [1:0] pattern_location_field;

    assign pattern_mode = mode_reg_three[DCP_MR3_ENABLE_BIT];
    assign pattern_location_field = mode_reg_three[1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn || dev_reset) begin
            mode_reg_zero <= '0;
            mode_reg_one <= '0;
            mode_reg_two <= '0;
            mode_reg_three <= '0;
        end else if (is_mrs) begin
            unique case (cmd_s2.ba)
                DCP_BA_MR0: mode_reg_zero <= cmd_s2.addr;
                DCP_BA_MR1: mode_reg_one <= cmd_s2.addr;
                DCP_BA_MR2: mode_reg_two <= cmd_s2.addr;
                DCP_BA_MR3: mode_reg_three <= cmd_s2.addr;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Read burst engine
    // ==========================================================
    dcp_state_e state;
    logic [3:0] lat_cnt, beat_idx, beat_end;
    logic from_pattern;
    logic [3:0] read_latency;
    logic chop, pat_bit;
    logic [7:0] array_data;
    logic [1:0] ctrl;
    logic [31:0] pattern_reads;

    // Additive plus CAS latency, shared by pattern and array reads.
    assign read_latency = 4'(dcp_cl(mode_reg_zero)
                           + dcp_al(mode_reg_one, dcp_cl(mode_reg_zero)));

    always_comb begin
        unique case (mode_reg_zero[1:0])
            DCP_BL_FIXED8: chop = 1'b0;
            DCP_BL_OTF: chop = !cmd_s2.addr[DCP_CHOP_BIT];
            default: chop = 1'b1;
        endcase
    end

    // Reserved locations return zero; the bank bits are never looked at.
    assign pat_bit = (pattern_location_field == 2'h0)
                     && DCP_CAL_PATTERN[beat_idx[2:0]];

    // A read arriving while a burst is pending is dropped; bursts are
    // single-issue to keep the engine small.
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_reset) begin
            state <= DCP_IDLE;
            lat_cnt <= 4'h0;
            beat_idx <= 4'h0;
            beat_end <= 4'h0;
            from_pattern <= 1'b0;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
        end else begin
            unique case (state)
                DCP_IDLE: begin
                    if (is_read) begin
                        state <= DCP_WAIT;
                        lat_cnt <= 4'(read_latency - 4'h1);
                        from_pattern <= pattern_mode;
                        beat_idx <= (chop && cmd_s2.addr[DCP_NIBBLE_BIT])
                                    ? DCP_BEATS_BC4 : 4'h0;
                        beat_end <= (chop && cmd_s2.addr[DCP_NIBBLE_BIT])
                                    ? DCP_BEATS_BL8
                                    : (chop ? DCP_BEATS_BC4 : DCP_BEATS_BL8);
                    end
                end
                DCP_WAIT: begin
                    if (ck_rise) begin
                        if (lat_cnt == 4'h0) begin
                            state <= DCP_BURST;
                        end else begin
                            lat_cnt <= lat_cnt - 4'h1;
                        end
                    end
                end
                DCP_BURST: begin
                    if (ck_edge) begin
                        if (beat_idx == beat_end) begin
                            state <= DCP_IDLE;
                            dq_oe <= 1'b0;
                            dq_out <= 8'h00;
                        end else begin
                            beat_idx <= beat_idx + 4'h1;
                            dq_oe <= 1'b1;
                            if (!from_pattern) begin
                                dq_out <= ctrl[DCP_CTRL_X8] ? array_data
                                          : {4'h0, array_data[3:0]};
                            end else if (ctrl[DCP_CTRL_X8]) begin
                                dq_out <= ctrl[DCP_CTRL_REPL] ? {8{pat_bit}}
                                          : {7'h00, pat_bit};
                            end else begin
                                dq_out <= {4'h0,
                                           ctrl[DCP_CTRL_REPL] ? {3{pat_bit}}
                                           : 3'h0, pat_bit};
                            end
                        end
                    end
                end
                default: state <= DCP_IDLE;
            endcase
        end
    end

    // Autoprecharge is honoured only for array reads.
    always_ff @(posedge aclk) begin
        if (!aresetn || dev_reset) begin
            bank_precharge <= 1'b0;
            pattern_reads <= 32'h0;
        end else begin
            bank_precharge <= is_read && !pattern_mode
                              && cmd_s2.addr[DCP_AP_BIT];
            if (is_read && pattern_mode && state == DCP_IDLE) begin
                pattern_reads <= pattern_reads + 32'h1;
            end
        end
    end

    // ==========================================================
    // Dynamic write termination
    // ==========================================================
    logic [4:0] wr_win;

    always_ff @(posedge aclk) begin
        if (!aresetn || dev_reset) begin
            wr_win <= 5'h00;
            term_code <= 3'h0;
            term_dynamic <= 1'b0;
        end else begin
            if (is_write && !pattern_mode) begin
                wr_win <= 5'(dcp_al(mode_reg_one, dcp_cl(mode_reg_zero))
                             + mode_reg_two[5:3] + DCP_CWL_BASE
                             + DCP_WR_BURST_CK);
            end else if (ck_rise && wr_win != 5'h00) begin
                wr_win <= wr_win - 5'h01;
            end
            if (cmd_s2.odt && wr_win != 5'h00 && mode_reg_two[10:9] != 2'h0
                && !mode_reg_one[DCP_MR1_WRLVL_BIT]) begin
                term_dynamic <= 1'b1;
                term_code <= {1'b0, mode_reg_two[10:9]};
            end else begin
                term_dynamic <= 1'b0;
                term_code <= cmd_s2.odt ? {mode_reg_one[9], mode_reg_one[6],
                                           mode_reg_one[2]} : 3'h0;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    // ==========================================================
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] next_rdata;
    logic rd_hit;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DCP_RESP_OKAY;
            ctrl <= DCP_CTRL_RESET;
            array_data <= DCP_ARRAY_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= DCP_RESP_OKAY;
                if (aw_addr == DCP_REG_CTRL) begin
                    if (w_strb[0]) begin
                        ctrl <= w_data[1:0];
                    end
                end else if (aw_addr == DCP_REG_ARRAY) begin
                    if (w_strb[0]) begin
                        array_data <= w_data[7:0];
                    end
                end else begin
                    s_axi_bresp <= DCP_RESP_DECERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            DCP_REG_CTRL: next_rdata = {30'h0, ctrl};
            DCP_REG_ARRAY: next_rdata = {24'h0, array_data};
            DCP_REG_STATUS: next_rdata = {27'h0, term_dynamic,
                                          state != DCP_IDLE,
                                          pattern_location_field,
                                          pattern_mode};
            DCP_REG_MR0: next_rdata = {17'h0, mode_reg_zero};
            DCP_REG_MR1: next_rdata = {17'h0, mode_reg_one};
            DCP_REG_MR2: next_rdata = {17'h0, mode_reg_two};
            DCP_REG_MR3: next_rdata = {17'h0, mode_reg_three};
            DCP_REG_COUNT: next_rdata = pattern_reads;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= DCP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_hit ? DCP_RESP_OKAY : DCP_RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_mrs_three;
        is_mrs && cmd_s2.ba == DCP_BA_MR3 && !dev_reset;
    endsequence

    sequence s_first_beat;
        ck_edge && state == DCP_BURST && !dq_oe && !dev_reset;
    endsequence

    a_mr3_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        s_mrs_three |=> mode_reg_three == $past(cmd_s2.addr))
        else $error("register three not captured");

    a_pattern_enter: assert property (@(posedge aclk) disable iff (!aresetn)
        s_mrs_three and cmd_s2.addr[2] |=> pattern_mode)
        else $error("pattern mode not entered");

    a_pin_reset_clears: assert property (@(posedge aclk)
        disable iff (!aresetn)
        dev_reset |=> !pattern_mode && !dq_oe)
        else $error("reset pin ignored");

    a_no_ap_pattern: assert property (@(posedge aclk) disable iff (!aresetn)
        is_read && pattern_mode |=> !bank_precharge)
        else $error("precharge in pattern mode");

    a_read_source: assert property (@(posedge aclk) disable iff (!aresetn)
        is_read && state == DCP_IDLE && !dev_reset
        |=> from_pattern == $past(pattern_mode))
        else $error("read source wrong");

    a_x4_lanes: assert property (@(posedge aclk) disable iff (!aresetn)
        dq_oe && from_pattern && !ctrl[DCP_CTRL_X8] |-> dq_out[7:4] == 4'h0
        && (dq_out[3:1] == 3'h0 || dq_out[3:1] == {3{dq_out[0]}}))
        else $error("four-bit lanes wrong");

    a_x8_lanes: assert property (@(posedge aclk) disable iff (!aresetn)
        dq_oe && from_pattern && ctrl[DCP_CTRL_X8] |->
        dq_out[7:1] == 7'h00 || dq_out[7:1] == {7{dq_out[0]}})
        else $error("eight-bit lanes wrong");

    a_pattern_first: assert property (@(posedge aclk) disable iff (!aresetn)
        s_first_beat ##0 from_pattern ##0 pattern_location_field == 2'h0
        |=> dq_oe && !dq_out[0])
        else $error("first pattern beat not zero");

    a_latency_load: assert property (@(posedge aclk) disable iff (!aresetn)
        is_read && state == DCP_IDLE && !dev_reset
        |=> state == DCP_WAIT && lat_cnt == 4'($past(read_latency) - 4'h1))
        else $error("read latency not loaded");

    a_wrlvl_nominal: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(mode_reg_one[DCP_MR1_WRLVL_BIT]) && !$past(dev_reset)
        |-> !term_dynamic)
        else $error("write termination in leveling");

endmodule

// >>> src/dcp_pkg.sv
package dcp_pkg;

    // ==========================================================
    // Command bus carrier
    // ==========================================================
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic odt;
        logic [2:0] ba;
        logic [14:0] addr;
    } dcp_cmd_s;

    typedef enum logic [1:0] {
        DCP_IDLE = 2'b00,
        DCP_WAIT = 2'b01,
        DCP_BURST = 2'b10
    } dcp_state_e;

    // ==========================================================
    // Mode register selection and fields
    // ==========================================================
    localparam logic [2:0] DCP_BA_MR0 = 3'h0;
    localparam logic [2:0] DCP_BA_MR1 = 3'h1;
    localparam logic [2:0] DCP_BA_MR2 = 3'h2;
    localparam logic [2:0] DCP_BA_MR3 = 3'h3;
    localparam int DCP_MR3_ENABLE_BIT = 2;
    localparam int DCP_MR1_WRLVL_BIT = 7;
    localparam int DCP_CHOP_BIT = 12;
    localparam int DCP_AP_BIT = 10;
    localparam int DCP_NIBBLE_BIT = 2;
    localparam logic [1:0] DCP_BL_FIXED8 = 2'h0;
    localparam logic [1:0] DCP_BL_OTF = 2'h1;
    localparam logic [7:0] DCP_CAL_PATTERN = 8'haa;
    localparam logic [3:0] DCP_CL_BASE = 4'h4;
    localparam logic [3:0] DCP_CWL_BASE = 4'h5;
    localparam logic [3:0] DCP_WR_BURST_CK = 4'h4;
    localparam logic [3:0] DCP_BEATS_BL8 = 4'h8;
    localparam logic [3:0] DCP_BEATS_BC4 = 4'h4;

    // ==========================================================
    // Register map and reset values
    // ==========================================================
    localparam logic [7:0] DCP_REG_CTRL = 8'h00;
    localparam logic [7:0] DCP_REG_ARRAY = 8'h04;
    localparam logic [7:0] DCP_REG_STATUS = 8'h08;
    localparam logic [7:0] DCP_REG_MR0 = 8'h0c;
    localparam logic [7:0] DCP_REG_MR1 = 8'h10;
    localparam logic [7:0] DCP_REG_MR2 = 8'h14;
    localparam logic [7:0] DCP_REG_MR3 = 8'h18;
    localparam logic [7:0] DCP_REG_COUNT = 8'h1c;
    localparam int DCP_CTRL_X8 = 0;
    localparam int DCP_CTRL_REPL = 1;
    localparam logic [1:0] DCP_CTRL_RESET = 2'h0;
    localparam logic [7:0] DCP_ARRAY_RESET = 8'h00;
    localparam logic [1:0] DCP_RESP_OKAY = 2'h0;
    localparam logic [1:0] DCP_RESP_DECERR = 2'h3;

endpackage

// >>> verification/dcp_ctrl_model.sv
`timescale 1ns/1ps

// ==========================================================
// Memory controller model: command issue and read capture
// ==========================================================
module dcp_ctrl_model (
    output logic ck,
    output dcp_pkg::dcp_cmd_s cmd_pins,
    input wire logic aclk,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe
);
    import dcp_pkg::*;
    int rise_cnt = 0;
    int start = 0;
    int nb = 0;
    int lat = 0;
    logic [7:0] beats [8];

    // The memory clock runs free, as it does in service.
    initial ck = 1'b0;
    always #40 ck = ~ck;
    always @(posedge ck) rise_cnt <= rise_cnt + 1;
    initial cmd_pins = '1;

    // Set up off the sampling edge and held for a full clock period.
    // Once released the lines show the inverse, so stale values never pass.
    // Termination select is a level the controller keeps driving.
    task automatic issue(input dcp_cmd_s c);
        @(negedge ck);
        cmd_pins <= c;
        @(posedge ck);
        start = rise_cnt;
        @(negedge ck);
        cmd_pins <= {1'b1, ~c[21:19], c.odt, ~c[17:0]};
    endtask

    // Beats are sampled mid-beat, a quarter clock period after each change.
    task automatic capture;
        int n;
        n = 0;
        nb = 0;
        lat = -1;
        while (dq_oe !== 1'b1 && n < 4000) begin
            @(negedge aclk);
            n++;
        end
        lat = rise_cnt - start - 1;
        while (dq_oe === 1'b1 && nb < 8) begin
            repeat (2) @(negedge aclk);
            beats[nb] = dq_out;
            nb++;
            repeat (2) @(negedge aclk);
        end
    endtask
endmodule

// >>> verification/dcp_calib_pattern_readout_test.sv
`timescale 1ns/1ps

module dcp_calib_pattern_readout_test;
    import dcp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic pin_reset_n = 1'b1;
    logic ck;
    dcp_cmd_s cmd_pins;
    logic [7:0] dq_out;
    logic [2:0] term_code;
    logic dq_oe, term_dynamic, bank_precharge;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic dyn_seen = 1'b0, pc_seen = 1'b0;
    logic [2:0] dyn_code = 3'h0;
    int err_count = 0, cmp_count = 0;

    dcp_calib_pattern_readout i_dut (.aclk, .aresetn, .ck, .pin_reset_n,
        .cmd_pins, .dq_out, .dq_oe, .term_code, .term_dynamic,
        .bank_precharge, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    dcp_ctrl_model i_ctrl (.ck, .cmd_pins, .aclk, .dq_out, .dq_oe);

    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (term_dynamic === 1'b1) dyn_seen <= 1'b1;
        if (term_dynamic === 1'b1) dyn_code <= term_code;
        if (bank_precharge === 1'b1) pc_seen <= 1'b1;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask

    function automatic dcp_cmd_s cmd(input logic [2:0] rcw,
        input logic [2:0] ba, input logic [14:0] a, input logic odt);
        return {1'b0, rcw, odt, ba, a};
    endfunction

    // No bank is ever opened, so every bank stays precharged and idle.
    task automatic mode_reg_set_cmd(input logic [2:0] ba, input logic [14:0] a);
        i_ctrl.issue(cmd(3'b000, ba, a, 1'b0));
    endtask

    // Issues one read, in either mode, and checks beat count, latency and each beat.
    task automatic rdb(input logic [2:0] ba, input logic [14:0] a,
        input int n, input int lat, input int first,
        input logic [7:0] pat, input logic [7:0] mask);
        i_ctrl.issue(cmd(3'b101, ba, a, 1'b0));
        i_ctrl.capture();
        chk("beat count", n, i_ctrl.nb);
        chk("read latency", lat, i_ctrl.lat);
        for (int i = 0; i < n; i++)
            chk("beat", pat[first+i] ? mask : 8'h00, i_ctrl.beats[i]);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs;
        axi_rd(DCP_REG_CTRL);
        chk("ctrl reset", 32'h0, rd);
        axi_rd(DCP_REG_ARRAY);
        chk("array reset", 32'h0, rd);
        axi_rd(8'h20);
        chk("unmapped read", DCP_RESP_DECERR, rs);
        axi_wr(8'h20, 32'h1);
        chk("unmapped write", DCP_RESP_DECERR, rs);
    endtask

    task automatic t_normal;
        axi_wr(DCP_REG_CTRL, 32'h1);
        axi_wr(DCP_REG_ARRAY, 32'h5a);
        mode_reg_set_cmd(DCP_BA_MR0, 15'h0010);
        mode_reg_set_cmd(DCP_BA_MR3, 15'h0001);
        mode_reg_set_cmd(3'h7, 15'h0004);
        axi_rd(DCP_REG_MR3);
        chk("mode three select", 32'h1, rd);
        rdb(3'h0, 15'h0400, 8, 5, 0, 8'hff, 8'h5a);
        chk("normal precharge", 1'b1, pc_seen);
    endtask

    task automatic t_term;
        dyn_seen <= 1'b0;
        mode_reg_set_cmd(DCP_BA_MR2, 15'h0200);
        i_ctrl.issue(cmd(3'b100, 3'h0, 15'h0, 1'b1));
        repeat (12) @(posedge ck);
        chk("dynamic term", 1'b1, dyn_seen);
        chk("dynamic code", 3'h1, dyn_code);
        mode_reg_set_cmd(DCP_BA_MR1, 15'h0080);
        dyn_seen <= 1'b0;
        i_ctrl.issue(cmd(3'b100, 3'h0, 15'h0, 1'b1));
        repeat (12) @(posedge ck);
        chk("leveling term", 1'b0, dyn_seen);
        mode_reg_set_cmd(DCP_BA_MR1, 15'h0000);
    endtask

    task automatic t_pattern;
        axi_wr(DCP_REG_CTRL, 32'h3);
        mode_reg_set_cmd(DCP_BA_MR3, 15'h0004);
        axi_rd(DCP_REG_STATUS);
        chk("pattern mode", 32'h1, rd & 32'h7);
        rdb(3'h0, 15'h0, 8, 5, 0, DCP_CAL_PATTERN, 8'hff);
        pc_seen <= 1'b0;
        rdb(3'h7, 15'h7ff8, 8, 5, 0, DCP_CAL_PATTERN, 8'hff);
        chk("pattern precharge", 1'b0, pc_seen);
    endtask

    // Locations one to three are reserved; only location zero is read in pattern mode.
    task automatic t_chop;
        mode_reg_set_cmd(DCP_BA_MR3, 15'h0000);
        mode_reg_set_cmd(DCP_BA_MR0, 15'h0011);
        mode_reg_set_cmd(DCP_BA_MR1, 15'h0008);
        mode_reg_set_cmd(DCP_BA_MR3, 15'h0004);
        axi_wr(DCP_REG_CTRL, 32'h2);
        rdb(3'h0, 15'h0, 4, 9, 0, DCP_CAL_PATTERN, 8'h0f);
        axi_wr(DCP_REG_CTRL, 32'h0);
        rdb(3'h0, 15'h0004, 4, 9, 4, DCP_CAL_PATTERN, 8'h01);
        rdb(3'h0, 15'h1000, 8, 9, 0, DCP_CAL_PATTERN, 8'h01);
        mode_reg_set_cmd(DCP_BA_MR3, 15'h0000);
        mode_reg_set_cmd(DCP_BA_MR0, 15'h0012);
        mode_reg_set_cmd(DCP_BA_MR3, 15'h0004);
        rdb(3'h0, 15'h1000, 4, 9, 0, DCP_CAL_PATTERN, 8'h01);
    endtask

    task automatic t_pinreset;
        @(posedge aclk) pin_reset_n <= 1'b0;
        repeat (6) @(posedge aclk);
        pin_reset_n <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(DCP_REG_STATUS);
        chk("reset pattern mode", 32'h0, rd & 32'h1);
        axi_rd(DCP_REG_MR3);
        chk("reset mode three", 32'h0, rd);
    endtask

    task automatic final_report;
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // A run takes well under a hundred microseconds.
    initial begin
        #400000;
        err_count++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_regs();
        t_normal();
        t_term();
        t_pattern();
        t_chop();
        t_pinreset();
        final_report();
    end
endmodule
